//--- pkg/pls_pkg.sv
// Behaviour
// - Latch fast link-drop cause in bits 8:4
// - Cause codes one-hot, five distinct modes
// - Bit 14 shows pair crossover state
// - Bit 13 latches rx error, clears 0x15
// - Bit 12 latches polarity, clears 0x1A
// - Bit 11 latches false carrier, clears 0x14
// - Bit 10 shows live signal detect
// - Bit 9 shows descrambler lock
// - Bit 8 page received, clears 0x06
// - Bit 7 interrupt pending, clears 0x12
// - Bit 6 remote fault, clears 0x01
// - Bit 5 jabber, status read keeps it
// - Bit 4 shows autonegotiation complete
// - Bit 3 shows MAC loopback enabled
// - Bit 2 shows full duplex
// - Bit 0 link status, status read keeps
package pls_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int CAUSE_W = 5;
  localparam int STICKY_W = 7;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [4:0] OFS_BASIC_MODE_STATUS = 5'h01;
  localparam logic [4:0] OFS_ANEXP = 5'h06;
  localparam logic [4:0] OFS_CAUSE = 5'h0F;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_IRQSRC = 5'h12;
  localparam logic [4:0] OFS_FCCNT = 5'h14;
  localparam logic [4:0] OFS_RXECNT = 5'h15;
  localparam logic [4:0] OFS_TENBT = 5'h1A;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CAUSE_LSB = 4;
  localparam int POS_SWAP = 14;
  localparam int POS_SIGDET = 10;
  localparam int POS_LOCK = 9;
  localparam int POS_ANDONE = 4;
  localparam int POS_LOOP = 3;
  localparam int POS_DUPLEX = 2;
  localparam int POS_SPEED = 1;
  localparam int POS_LINK = 0;

  // Sticky vector index and matching status bit
  localparam int SI_RXERR = 0;
  localparam int SI_POL = 1;
  localparam int SI_FCAR = 2;
  localparam int SI_PAGE = 3;
  localparam int SI_IRQ = 4;
  localparam int SI_RFLT = 5;
  localparam int SI_JAB = 6;
  localparam int POS_RXERR = 13;
  localparam int POS_POL = 12;
  localparam int POS_FCAR = 11;
  localparam int POS_PAGE = 8;
  localparam int POS_IRQ = 7;
  localparam int POS_RFLT = 6;
  localparam int POS_JAB = 5;

  // ----------------------------------------
  // Cause codes, one-hot
  // ----------------------------------------
  localparam logic [4:0] CAUSE_ENERGY = 5'h01;
  localparam logic [4:0] CAUSE_SNR = 5'h02;
  localparam logic [4:0] CAUSE_MLT3 = 5'h04;
  localparam logic [4:0] CAUSE_RXERR = 5'h08;
  localparam logic [4:0] CAUSE_DESCR = 5'h10;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] RST_STATUS = 16'h0000;
  localparam logic [4:0] RST_CAUSE = 5'h00;
  localparam logic [6:0] RST_STICKY = 7'h00;

endpackage : pls_pkg

//--- core/pls_sticky.sv
`timescale 1ns/1ps
// ----------------------------------------
// Bank of set-dominant sticky flags
// ----------------------------------------
module pls_sticky #(
  parameter int W = 7
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] q
);

  // Flag storage
  logic [W-1:0] flag_r;
  // Next flag value
  logic [W-1:0] flag_nxt;

  // Set beats a clear in the same cycle
  always_comb begin
    flag_nxt = (flag_r & ~clr) | set;
  end

  // Flags held while clock enable is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= '0;
    end else if (ce) begin
      flag_r <= flag_nxt;
    end
  end

  assign q = flag_r;

endmodule : pls_sticky

//--- core/pls_status_regs.sv
`timescale 1ns/1ps
// ----------------------------------------
// Link drop cause and PHY status registers
// ----------------------------------------
module pls_status_regs (
  // Core clock
  input wire logic ref_clk,
  // Asynchronous reset
  input wire logic rst_n,
  // Clock enable
  input wire logic ce,
  // Management read strobe
  input wire logic reg_rd_stb,
  // Management register address
  input wire logic [4:0] reg_addr,
  // Read data, registered
  output logic [15:0] reg_rd_data,
  // Read data valid pulse
  output logic reg_rd_valid,
  // Address was one of ours
  output logic reg_rd_hit,
  // Fast link-drop mode enables
  input wire logic [4:0] fld_enable,
  // Fast link-drop mode triggers
  input wire logic [4:0] fld_trigger,
  // Link dropped by a fast mode
  output logic link_drop,
  // Pair crossover active
  input wire logic pair_swap_state,
  // Receive error event pulse
  input wire logic rx_err_evt,
  // Inverted polarity seen
  input wire logic polarity_inv,
  // False carrier event pulse
  input wire logic false_carrier_evt,
  // Unconditional signal detect
  input wire logic signal_detect,
  // Descrambler locked
  input wire logic descr_lock,
  // New page received pulse
  input wire logic page_rcvd_evt,
  // Internal interrupt raised
  input wire logic irq_pending_evt,
  // Remote fault from partner
  input wire logic remote_fault_evt,
  // Jabber seen at 10 Mbps
  input wire logic jabber_evt,
  // Autonegotiation complete
  input wire logic autoneg_done,
  // MAC loopback enabled
  input wire logic mac_loopback,
  // Resolved full duplex
  input wire logic full_duplex,
  // Running at 10 Mbps
  input wire logic speed_10,
  // Live link valid
  input wire logic link_up,
  // Status word view, registered
  output logic [15:0] phy_status
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------

  // Read of a given register this cycle
  function automatic logic rd_of(
    input logic stb,
    input logic [4:0] addr,
    input logic [4:0] ofs
  );
    rd_of = stb && (addr == ofs);
  endfunction : rd_of

  // Keep lowest set bit so result stays one-hot
  function automatic logic [4:0] pick_one(
    input logic [4:0] v
  );
    pick_one = v & (~v + 5'h01);
  endfunction : pick_one

  // ----------------------------------------
  // Reset synchroniser
  // ----------------------------------------

  // First reset stage
  logic rst_s1_r;
  // Second reset stage, used by all logic
  logic rst_s2_r;

  // Release is synchronous, assert is not
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // Internal reset, active low
  logic rst_int_n;
  assign rst_int_n = rst_s2_r;

  // ----------------------------------------
  // Read decode
  // ----------------------------------------

  // Clear strobes from reads of other registers
  logic rd_basic_mode_status;
  logic rd_anexp;
  logic rd_irqsrc;
  logic rd_fccnt;
  logic rd_rxecnt;
  logic rd_tenbt;
  // Reads of our own two registers
  logic rd_cause;
  logic rd_status;

  // Strobes only count while enabled
  always_comb begin
    rd_basic_mode_status = rd_of(reg_rd_stb & ce, reg_addr, pls_pkg::OFS_BASIC_MODE_STATUS);
    rd_anexp = rd_of(reg_rd_stb & ce, reg_addr, pls_pkg::OFS_ANEXP);
    rd_irqsrc = rd_of(reg_rd_stb & ce, reg_addr, pls_pkg::OFS_IRQSRC);
    rd_fccnt = rd_of(reg_rd_stb & ce, reg_addr, pls_pkg::OFS_FCCNT);
    rd_rxecnt = rd_of(reg_rd_stb & ce, reg_addr, pls_pkg::OFS_RXECNT);
    rd_tenbt = rd_of(reg_rd_stb & ce, reg_addr, pls_pkg::OFS_TENBT);
    rd_cause = rd_of(reg_rd_stb & ce, reg_addr, pls_pkg::OFS_CAUSE);
    rd_status = rd_of(reg_rd_stb & ce, reg_addr, pls_pkg::OFS_STATUS);
  end

  // ----------------------------------------
  // Fast link-drop cause
  // ----------------------------------------

  // Enabled modes that fired this cycle
  logic [4:0] fld_hit;
  // Cause field storage
  logic [4:0] cause_r;
  // Cause field next value
  logic [4:0] cause_nxt;
  // Link drop pulse register
  logic link_drop_r;

  // Only enabled modes may record a cause
  always_comb begin
    fld_hit = fld_enable & fld_trigger;
  end

  // Hold cause; own read clears, new drop wins
  always_comb begin
    cause_nxt = cause_r;
    if (fld_hit != 5'h00) begin
      // Single cause even if several fire
      cause_nxt = pick_one(fld_hit);
    end else if (rd_cause) begin
      // Cleared once software has seen it
      cause_nxt = pls_pkg::RST_CAUSE;
    end
  end

  // Cause register
  always_ff @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      cause_r <= pls_pkg::RST_CAUSE;
    end else if (ce) begin
      cause_r <= cause_nxt;
    end
  end

  // One-cycle notice that the link was forced down
  always_ff @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      link_drop_r <= 1'b0;
    end else if (ce) begin
      link_drop_r <= (fld_hit != 5'h00);
    end
  end

  // ----------------------------------------
  // Latched event bits
  // ----------------------------------------

  // Set terms, one per sticky flag
  logic [6:0] stk_set;
  // Clear terms, one per sticky flag
  logic [6:0] stk_clr;
  // Sticky flag values
  logic [6:0] stk_q;

  // Event sources
  always_comb begin
    stk_set = '0;
    stk_set[pls_pkg::SI_RXERR] = rx_err_evt;
    stk_set[pls_pkg::SI_POL] = polarity_inv;
    stk_set[pls_pkg::SI_FCAR] = false_carrier_evt;
    stk_set[pls_pkg::SI_PAGE] = page_rcvd_evt;
    stk_set[pls_pkg::SI_IRQ] = irq_pending_evt;
    stk_set[pls_pkg::SI_RFLT] = remote_fault_evt;
    stk_set[pls_pkg::SI_JAB] = jabber_evt;
  end

  // Clears come only from reads of other registers
  always_comb begin
    stk_clr = '0;
    stk_clr[pls_pkg::SI_RXERR] = rd_rxecnt;
    stk_clr[pls_pkg::SI_POL] = rd_tenbt;
    stk_clr[pls_pkg::SI_FCAR] = rd_fccnt;
    stk_clr[pls_pkg::SI_PAGE] = rd_anexp;
    stk_clr[pls_pkg::SI_IRQ] = rd_irqsrc;
    stk_clr[pls_pkg::SI_RFLT] = rd_basic_mode_status;
    stk_clr[pls_pkg::SI_JAB] = rd_basic_mode_status;
  end

  // Set-dominant flag bank
  pls_sticky #(
    .W(pls_pkg::STICKY_W)
  ) u_sticky (
    .clk(ref_clk),
    .rst_n(rst_int_n),
    .ce(ce),
    .set(stk_set),
    .clr(stk_clr),
    .q(stk_q)
  );

  // ----------------------------------------
  // Link status, latched low
  // ----------------------------------------

  // Latched link bit
  logic link_r;
  // Latched link next value
  logic link_nxt;

  // Drop sticks until the basic status read
  always_comb begin
    if (rd_basic_mode_status) begin
      // Read reloads from the live line
      link_nxt = link_up;
    end else begin
      // Any loss pulls it low and keeps it there
      link_nxt = link_r & link_up;
    end
  end

  // Status reads never touch this bit
  always_ff @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      link_r <= 1'b0;
    end else if (ce) begin
      link_r <= link_nxt;
    end
  end

  // ----------------------------------------
  // Status word assembly
  // ----------------------------------------

  // Current status word
  logic [15:0] sts_word;

  // Reserved bits left at zero
  always_comb begin
    sts_word = pls_pkg::RST_STATUS;
    sts_word[pls_pkg::POS_SWAP] = pair_swap_state;
    sts_word[pls_pkg::POS_RXERR] = stk_q[pls_pkg::SI_RXERR];
    sts_word[pls_pkg::POS_POL] = stk_q[pls_pkg::SI_POL];
    sts_word[pls_pkg::POS_FCAR] = stk_q[pls_pkg::SI_FCAR];
    sts_word[pls_pkg::POS_SIGDET] = signal_detect;
    sts_word[pls_pkg::POS_LOCK] = descr_lock;
    sts_word[pls_pkg::POS_PAGE] = stk_q[pls_pkg::SI_PAGE];
    sts_word[pls_pkg::POS_IRQ] = stk_q[pls_pkg::SI_IRQ];
    sts_word[pls_pkg::POS_RFLT] = stk_q[pls_pkg::SI_RFLT];
    sts_word[pls_pkg::POS_JAB] = stk_q[pls_pkg::SI_JAB];
    sts_word[pls_pkg::POS_ANDONE] = autoneg_done;
    sts_word[pls_pkg::POS_LOOP] = mac_loopback;
    sts_word[pls_pkg::POS_DUPLEX] = full_duplex;
    sts_word[pls_pkg::POS_SPEED] = speed_10;
    sts_word[pls_pkg::POS_LINK] = link_r;
  end

  // Cause register image, reserved bits zero
  logic [15:0] cause_word;
  always_comb begin
    cause_word = 16'h0000;
    cause_word[pls_pkg::CAUSE_LSB +: pls_pkg::CAUSE_W] = cause_r;
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------

  // Read data register
  logic [15:0] rd_data_r;
  // Read valid register
  logic rd_valid_r;
  // Address hit register
  logic rd_hit_r;
  // Status view register
  logic [15:0] sts_view_r;

  // Capture before any clear of the same cycle lands
  always_ff @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      rd_data_r <= 16'h0000;
      rd_hit_r <= 1'b0;
    end else if (ce && reg_rd_stb) begin
      if (rd_status) begin
        // Status read has no side effect
        rd_data_r <= sts_word;
        rd_hit_r <= 1'b1;
      end else if (rd_cause) begin
        // Cause field in bits 8:4
        rd_data_r <= cause_word;
        rd_hit_r <= 1'b1;
      end else begin
        // Other addresses answer zero
        rd_data_r <= 16'h0000;
        rd_hit_r <= 1'b0;
      end
    end
  end

  // One pulse per accepted read
  always_ff @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      rd_valid_r <= 1'b0;
    end else if (ce) begin
      rd_valid_r <= reg_rd_stb;
    end
  end

  // Free-running copy of the status word
  always_ff @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      sts_view_r <= pls_pkg::RST_STATUS;
    end else if (ce) begin
      sts_view_r <= sts_word;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rd_data = rd_data_r;
  assign reg_rd_valid = rd_valid_r;
  assign reg_rd_hit = rd_hit_r;
  assign link_drop = link_drop_r;
  assign phy_status = sts_view_r;

endmodule : pls_status_regs

//--- test/pls_status_regs_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker for the status registers
// ----------------------------------------
module pls_status_regs_monitor (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic reg_rd_stb,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_rd_data,
  input wire logic reg_rd_valid,
  input wire logic reg_rd_hit,
  input wire logic [4:0] fld_enable,
  input wire logic [4:0] fld_trigger,
  input wire logic link_drop,
  input wire logic pair_swap_state,
  input wire logic signal_detect,
  input wire logic descr_lock,
  input wire logic rx_err_evt,
  input wire logic full_duplex,
  input wire logic speed_10,
  input wire logic [15:0] phy_status
);
  logic [2:0] rcnt_r; // Edges since reset release
  logic run; // Reset synchroniser has settled
  // Settling counter, skips the synchroniser edges
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rcnt_r <= 3'h0;
    end else if (rcnt_r != 3'h4) begin
      rcnt_r <= rcnt_r + 3'h1;
    end
  end
  assign run = (rcnt_r == 3'h4);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_RD_VALID: assert property (run && ce && reg_rd_stb |=> reg_rd_valid)
    else $error("read strobe not answered");
  AST_RD_HIT: assert property (run && reg_rd_valid |->
    reg_rd_hit == ($past(reg_addr) inside {5'h0F, 5'h10})) else $error("hit flag wrong");
  AST_CAUSE_RSVD: assert property (run && reg_rd_valid && $past(reg_addr) == 5'h0F |->
    reg_rd_data[15:9] == 7'h00 && reg_rd_data[3:0] == 4'h0) else $error("cause reserved set");
  AST_CAUSE_ONEHOT: assert property (run && reg_rd_valid && $past(reg_addr) == 5'h0F |->
    $onehot0(reg_rd_data[8:4])) else $error("cause not one-hot");
  AST_DROP_SET: assert property (run && ce && |(fld_enable & fld_trigger) |=> link_drop)
    else $error("enabled trigger gave no drop");
  AST_DROP_CAUSE: assert property (run && link_drop |->
    $past(ce && |(fld_enable & fld_trigger))) else $error("drop without enabled trigger");
  AST_SWAP: assert property (run && $past(ce) |-> phy_status[14] == $past(pair_swap_state))
    else $error("swap bit wrong");
  AST_SIGDET: assert property (run && $past(ce) |-> phy_status[10] == $past(signal_detect))
    else $error("signal detect bit wrong");
  AST_LOCK: assert property (run && $past(ce) |-> phy_status[9] == $past(descr_lock))
    else $error("lock bit wrong");
  AST_DUPLEX: assert property (run && $past(ce) |-> phy_status[2] == $past(full_duplex))
    else $error("duplex bit wrong");
  AST_SPEED: assert property (run && $past(ce) |-> phy_status[1] == $past(speed_10))
    else $error("speed bit wrong");
  AST_RXERR: assert property (run && ce && rx_err_evt ##1 ce |=> phy_status[13])
    else $error("rx error not latched");
  AST_STS_RSVD: assert property (run |-> !phy_status[15])
    else $error("status reserved set");
  COV_DROP: cover property (run && link_drop);
  COV_HIT: cover property (run && reg_rd_valid && reg_rd_hit);
  COV_RXERR: cover property (run && phy_status[13]);
endmodule : pls_status_regs_monitor

bind pls_status_regs pls_status_regs_monitor u_mon (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
  .reg_rd_stb(reg_rd_stb), .reg_addr(reg_addr), .reg_rd_data(reg_rd_data),
  .reg_rd_valid(reg_rd_valid), .reg_rd_hit(reg_rd_hit), .fld_enable(fld_enable),
  .fld_trigger(fld_trigger), .link_drop(link_drop), .pair_swap_state(pair_swap_state),
  .signal_detect(signal_detect), .descr_lock(descr_lock), .rx_err_evt(rx_err_evt),
  .full_duplex(full_duplex), .speed_10(speed_10), .phy_status(phy_status));

//--- test/pls_smc_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Management controller issuing reads
// ----------------------------------------
module pls_smc_model (
  input wire logic ref_clk,
  output logic reg_rd_stb,
  output logic [4:0] reg_addr,
  input wire logic reg_rd_valid,
  input wire logic [15:0] reg_rd_data
);
  // Idle bus at time zero
  initial begin
    reg_rd_stb = 1'b0;
    reg_addr = 5'h00;
  end
  // One read; a missing answer returns unknown data
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    int n;
    @(posedge ref_clk);
    reg_rd_stb <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd_stb <= 1'b0;
    reg_addr <= ~a; // Released address no longer shows the last value
    n = 0;
    @(posedge ref_clk);
    while (reg_rd_valid !== 1'b1 && n < 4) begin
      @(posedge ref_clk);
      n++;
    end
    d = (reg_rd_valid === 1'b1) ? reg_rd_data : 16'hXXXX;
  endtask : rd
endmodule : pls_smc_model

//--- test/pls_status_regs_tb.sv
`timescale 1ns/1ps
module pls_status_regs_tb;
  logic ref_clk, rst_n, ce, stb, rd_valid, rd_hit, link_drop, link_up;
  logic [4:0] addr, fld_en, fld_trig;
  logic [15:0] rd_data, phy_status, d;
  logic [6:0] evt; // Sticky events, rx error first, jabber last
  logic [6:0] live; // Swap, detect, lock, autoneg, loopback, duplex, speed
  int num_errors, samples_checked;
  int pos[7] = '{13, 12, 11, 8, 7, 6, 5}; // Status bit of each event
  logic [4:0] clr_a[7] = '{5'h15, 5'h1A, 5'h14, 5'h06, 5'h12, 5'h01, 5'h01}; // Clearing reads

  pls_status_regs uut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .reg_rd_stb(stb),
    .reg_addr(addr), .reg_rd_data(rd_data), .reg_rd_valid(rd_valid), .reg_rd_hit(rd_hit),
    .fld_enable(fld_en), .fld_trigger(fld_trig), .link_drop(link_drop),
    .pair_swap_state(live[6]), .rx_err_evt(evt[0]), .polarity_inv(evt[1]),
    .false_carrier_evt(evt[2]), .signal_detect(live[5]), .descr_lock(live[4]),
    .page_rcvd_evt(evt[3]), .irq_pending_evt(evt[4]), .remote_fault_evt(evt[5]),
    .jabber_evt(evt[6]), .autoneg_done(live[3]), .mac_loopback(live[2]),
    .full_duplex(live[1]), .speed_10(live[0]), .link_up(link_up), .phy_status(phy_status));
  pls_smc_model u_smc (.ref_clk(ref_clk), .reg_rd_stb(stb), .reg_addr(addr),
    .reg_rd_valid(rd_valid), .reg_rd_data(rd_data));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Reset values and an unmapped address
  task automatic t_reset_vals();
    u_smc.rd(5'h10, d); chk(d, 16'h0000);
    chk({15'h0000, rd_hit}, 16'h0001);
    u_smc.rd(5'h0F, d); chk(d, 16'h0000);
    u_smc.rd(5'h1F, d); chk(d, 16'h0000);
    chk({15'h0000, rd_hit}, 16'h0000);
  endtask : t_reset_vals
  // Live bits follow inputs in two opposite patterns
  task automatic t_live();
    logic [6:0] pat[2] = '{7'h55, 7'h2A};
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk) live <= pat[i];
      u_smc.rd(5'h10, d);
      // Bit 15 reserved, 14 swap, 10:9 detect and lock, 4:1 autoneg to speed
      chk(d, {1'h0, pat[i][6], 3'h0, pat[i][5:4], 4'h0, pat[i][3:0], 1'h0});
      chk(d, {1'h0, pat[i][6], 3'h0, pat[i][5:4], 4'h0, pat[i][3:0], 1'h0});
    end
    @(posedge ref_clk) live <= 7'h00;
  endtask : t_live
  // Each sticky bit survives status reads and clears on its own read
  task automatic t_sticky();
    for (int i = 0; i < 7; i++) begin
      @(posedge ref_clk) evt <= 7'h01 << i;
      @(posedge ref_clk) evt <= 7'h00;
      u_smc.rd(5'h10, d); chk(d, 16'h0001 << pos[i]);
      u_smc.rd(5'h10, d); chk(d, 16'h0001 << pos[i]);
      u_smc.rd(clr_a[i], d);
      u_smc.rd(5'h10, d); chk(d, 16'h0000);
    end
  endtask : t_sticky
  // Frozen clock enable: no event latched, no clear by a read
  task automatic t_freeze();
    @(posedge ref_clk) evt <= 7'h01;
    @(posedge ref_clk) begin
      // Polarity event arrives while frozen
      evt <= 7'h02;
      ce <= 1'b0;
    end
    @(posedge ref_clk) evt <= 7'h00;
    // Ignored read, no answer and no clear
    u_smc.rd(5'h15, d);
    @(posedge ref_clk) ce <= 1'b1;
    u_smc.rd(5'h10, d); chk(d, 16'h2000);
    u_smc.rd(5'h15, d);
    u_smc.rd(5'h10, d); chk(d, 16'h0000);
  endtask : t_freeze
  // Reset in mid-run clears latched bits
  task automatic t_rst_mid();
    @(posedge ref_clk) evt <= 7'h21;
    @(posedge ref_clk) evt <= 7'h00;
    u_smc.rd(5'h10, d); chk(d, 16'h2040);
    @(posedge ref_clk) rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    u_smc.rd(5'h10, d); chk(d, 16'h0000);
  endtask : t_rst_mid
  // Link bit reloads on a basic status read, status read keeps it
  task automatic t_link();
    @(posedge ref_clk) link_up <= 1'b1;
    u_smc.rd(5'h01, d);
    u_smc.rd(5'h10, d); chk(d, 16'h0001);
    u_smc.rd(5'h10, d); chk(d, 16'h0001);
    @(posedge ref_clk) link_up <= 1'b0;
    u_smc.rd(5'h10, d); chk(d, 16'h0000);
    // Link returns but the loss stays latched
    @(posedge ref_clk) link_up <= 1'b1;
    u_smc.rd(5'h10, d); chk(d, 16'h0000);
    u_smc.rd(5'h01, d);
    u_smc.rd(5'h10, d); chk(d, 16'h0001);
  endtask : t_link
  // One trigger into the cause field and drop pulse
  task automatic trig(input logic [4:0] m, input logic [15:0] drop, input logic [15:0] exp);
    @(posedge ref_clk) fld_trig <= m;
    @(posedge ref_clk) fld_trig <= 5'h00;
    #1 chk({15'h0000, link_drop}, drop);
    u_smc.rd(5'h0F, d); chk(d, exp);
    u_smc.rd(5'h0F, d); chk(d, 16'h0000);
  endtask : trig
  // Every mode, a double trigger, then modes disabled
  task automatic t_cause();
    @(posedge ref_clk) fld_en <= 5'h1F;
    for (int i = 0; i < 5; i++) trig(5'h01 << i, 16'h0001, {7'h00, 5'h01 << i, 4'h0});
    trig(5'h06, 16'h0001, 16'h0020);
    @(posedge ref_clk) fld_en <= 5'h00;
    trig(5'h1F, 16'h0000, 16'h0000);
  endtask : t_cause

  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    #50us;
    num_errors++;
    end_of_test();
  end
  initial begin
    {rst_n, ce, link_up, evt, live, fld_en, fld_trig} = '0;
    ce = 1'b1;
    num_errors = 0;
    samples_checked = 0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset_vals();
    t_live();
    t_sticky();
    t_freeze();
    t_rst_mid();
    t_link();
    t_cause();
    end_of_test();
  end
endmodule : pls_status_regs_tb
